// *** shared/ssh_pkg.sv ***
// Shared constants and types for the sensor serial host port
package ssh_pkg;

    // Register space
    localparam int REG_AW = 6;
    localparam int REG_COUNT = 64;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [5:0] ADDR_PRESET = 6'h3c;
    localparam logic [5:0] ADDR_CALIB = 6'h3d;
    localparam logic [7:0] CMD_MAGIC = 8'h96;

    // Serial command word: mode in bits 15:14, address 13:8, data 7:0
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_READ = 2'h1;
    localparam logic [4:0] CNT_HEAD = 5'h07;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam logic [4:0] CNT_DONE = 5'h10;
    localparam logic [4:0] CNT_BURST = 5'h08;

    // Two-wire device address: fixed nibble zero-extended to five bits, then pins
    localparam logic [3:0] DEV_PREFIX = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // Synchroniser lanes
    localparam int SY_W = 7;
    localparam int SY_SEL = 0;
    localparam int SY_SCL = 1;
    localparam int SY_SDA = 2;
    localparam int SY_A0 = 3;
    localparam int SY_A1 = 4;
    localparam int SY_CS = 5;
    localparam int SY_TGL = 6;

    // Request from the serial clock domain
    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] data;
    } ssh_spi_req_type;

    typedef enum logic [3:0] {
        I2C_IDLE, I2C_DEV, I2C_DEV_ACK, I2C_PTR, I2C_PTR_ACK,
        I2C_WR, I2C_WR_ACK, I2C_TX, I2C_TX_ACK, I2C_WAIT
    } ssh_i2c_state_type;

endpackage : ssh_pkg

// *** hdl/ssh_spi_link.sv ***
// Serial link shifter running on the serial clock
module ssh_spi_link
    import ssh_pkg::*;
(
    // Link pins and reset
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic rst_n_i,
    // Request word and its toggle towards the core
    output ssh_spi_req_type req_o,
    output logic req_tgl_o,
    // Read data held stable by the core
    input wire logic [7:0] rd_data_i,
    output logic miso_o
);

    typedef struct packed {
        logic [4:0] cnt;
        logic [14:0] sh;
        logic [1:0] mode;
        logic [5:0] addr;
    } ssh_frame_type;

    typedef struct packed {
        logic tgl;
        ssh_spi_req_type req;
    } ssh_evt_type;

    ssh_frame_type fr_q, fr_d;
    ssh_evt_type ev_q, ev_d;
    logic [7:0] out_q, out_d;
    logic frame_rst_n;
    logic [15:0] word;

    // Chip select high holds the frame logic in reset
    assign frame_rst_n = rst_n_i & ~spi_cs_n_i;

    // Sample on the falling edge, decode head and tail of the word
    always_comb
    begin
        fr_d = fr_q;
        ev_d = ev_q;
        word = {fr_q.sh, spi_mosi_i};
        fr_d.sh = word[14:0];
        if (fr_q.cnt != CNT_DONE)
            fr_d.cnt = fr_q.cnt + 5'h01;
        if (fr_q.cnt == CNT_HEAD)
        begin
            fr_d.mode = word[7:6];
            fr_d.addr = word[5:0];
            if (word[7:6] == MODE_READ)
            begin
                ev_d.req = '{wr: 1'b0, addr: word[5:0], data: 8'h00};
                ev_d.tgl = ~ev_q.tgl;
            end
        end
        if (fr_q.cnt == CNT_LAST && fr_q.mode == MODE_WRITE)
        begin
            ev_d.req = '{wr: 1'b1, addr: fr_q.addr, data: word[7:0]};
            ev_d.tgl = ~ev_q.tgl;
        end
        if (fr_q.cnt == CNT_LAST && fr_q.mode == MODE_READ)
        begin
            // Burst: next address, wrap the count to re-arm
            fr_d.addr = fr_q.addr + 6'h01;
            fr_d.cnt = CNT_BURST;
            ev_d.req = '{wr: 1'b0, addr: fr_q.addr + 6'h01, data: 8'h00};
            ev_d.tgl = ~ev_q.tgl;
        end
    end

    // Frame state clears with chip select
    always_ff @(negedge spi_clk_i or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            fr_q <= '0;
        else
            fr_q <= fr_d;
    end

    // Toggle survives frames so the core never sees a false event
    always_ff @(negedge spi_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ev_q <= '0;
        else
            ev_q <= ev_d;
    end

    // Launch on rising edge; rd_data settles within the half period before it
    always_comb
    begin
        out_d = {out_q[6:0], 1'b0};
        if (fr_q.cnt == CNT_BURST && fr_q.mode == MODE_READ)
            out_d = rd_data_i;
    end

    always_ff @(posedge spi_clk_i or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            out_q <= '0;
        else
            out_q <= out_d;
    end

    assign req_o = ev_q.req;
    assign req_tgl_o = ev_q.tgl;
    assign miso_o = out_q[7];

endmodule : ssh_spi_link

// *** hdl/ssh_serial_host_port.sv ***
// Register access port with serial link and two-wire slave
//
// Functional notes
// - Serial link is the register port only while interface select is low.
// - Serial link runs mode 1; data sampled on falling clock edge.
// - Transactions start with chip select low; clock ignored while high.
// - Data out pin is released whenever chip select is high.
// - Bits 15:14 give mode: 00 write or command, 01 read.
// - Bits 13:8 give the binary register address.
// - Read shifts the addressed register out after the address bits.
// - Burst read: held chip select steps to each next register.
// - 0x96 written to 0x3c restores every register to default.
// - 0x96 written to 0x3d starts oscillator calibration.
// - Two-wire slave is the register port only while select is high.
// - Two-wire slave reads, writes and takes commands like the link.
// - Two-wire address is 00000, addr pins 1 and 0, then direction.
// - Write: first byte sets pointer, later bytes stored with increment.
// - Read address sends register at pointer, incrementing per byte.
module ssh_serial_host_port
    import ssh_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Interface select strap
    input wire logic intf_sel_i,
    // Serial link
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Two-wire slave pins
    input wire logic two_wire_clock_pin_i,
    input wire logic two_wire_data_pin_i,
    output logic two_wire_data_pin_o,
    output logic two_wire_data_pin_oe_o,
    input wire logic addr_pin_0_i,
    input wire logic addr_pin_1_i,
    // Register contents and command pulses
    output logic [REG_COUNT-1:0][7:0] reg_file_o,
    output logic restore_defaults_o,
    output logic rc_osc_calibrate_cmd_o
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [SY_W-1:0] sy1;
        logic [SY_W-1:0] sy2;
        logic scl_prev;
        logic sda_prev;
        logic tgl_seen;
        logic [7:0] rd_data;
        logic miso_oe;
        logic [REG_COUNT-1:0][7:0] regs;
        logic preset;
        logic calib;
        ssh_i2c_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [5:0] ptr;
        logic sda_oe;
        logic sda_o;
    } ssh_core_type;

    localparam ssh_core_type CORE_RESET = '{
        regs: {REG_COUNT{REG_RESET_VAL}},
        st: I2C_IDLE,
        default: '0
    };

    ssh_core_type s_q, s_d;

    ssh_spi_req_type spi_req;
    logic spi_tgl;
    logic spi_miso;

    logic spi_sel;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic dev_match;

    logic wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;

    ////////////////////////////////////////////////////////////////////////////

    // Link-clock shifter; it only ever hands over held words
    ssh_spi_link u_link (
        .spi_clk_i (spi_clk_i),
        .spi_cs_n_i (spi_cs_n_i),
        .spi_mosi_i (spi_mosi_i),
        .rst_n_i (rst_n_i),
        .req_o (spi_req),
        .req_tgl_o (spi_tgl),
        .rd_data_i (s_q.rd_data),
        .miso_o (spi_miso)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Decoded pin events, all taken from second sync stage
    always_comb
    begin
        spi_sel = ~s_q.sy2[SY_SEL];
        scl = s_q.sy2[SY_SCL];
        sda = s_q.sy2[SY_SDA];
        scl_rise = scl & ~s_q.scl_prev;
        scl_fall = ~scl & s_q.scl_prev;
        // Data edges while clock stays high frame the transfer
        i2c_start = scl & s_q.scl_prev & s_q.sda_prev & ~sda;
        i2c_stop = scl & s_q.scl_prev & ~s_q.sda_prev & sda;
        dev_match = s_q.sh[7:1] == {DEV_PREFIX, s_q.sy2[SY_A1], s_q.sy2[SY_A0]};
    end

    ////////////////////////////////////////////////////////////////////////////

    // Main next-state logic
    always_comb
    begin
        s_d = s_q;
        wr_en = 1'b0;
        wr_addr = 6'h00;
        wr_data = 8'h00;

        // Two-flop synchronisers for pins and the link toggle
        s_d.sy1 = {spi_tgl, spi_cs_n_i, addr_pin_1_i, addr_pin_0_i,
                   two_wire_data_pin_i, two_wire_clock_pin_i, intf_sel_i};
        s_d.sy2 = s_q.sy1;
        s_d.scl_prev = scl;
        s_d.sda_prev = sda;
        s_d.preset = 1'b0;
        s_d.calib = 1'b0;
        s_d.sda_o = 1'b0;

        // Data out pin driven only during a selected frame
        s_d.miso_oe = spi_sel & ~s_q.sy2[SY_CS];

        // Link requests: word is stable once its toggle has synced
        if (s_q.sy2[SY_TGL] != s_q.tgl_seen)
        begin
            s_d.tgl_seen = s_q.sy2[SY_TGL];
            if (spi_sel && spi_req.wr)
            begin
                wr_en = 1'b1;
                wr_addr = spi_req.addr;
                wr_data = spi_req.data;
            end
            else if (spi_sel)
            begin
                s_d.rd_data = s_q.regs[spi_req.addr];
            end
        end

        // Two-wire slave, parked while the link is selected
        if (spi_sel)
        begin
            s_d.st = I2C_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else if (i2c_start)
        begin
            // Repeated start keeps the pointer
            s_d.st = I2C_DEV;
            s_d.cnt = 4'h0;
            s_d.sda_oe = 1'b0;
        end
        else if (i2c_stop)
        begin
            s_d.st = I2C_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (s_q.st)
                I2C_DEV, I2C_PTR, I2C_WR:
                begin
                    s_d.sh = {s_q.sh[6:0], sda};
                    s_d.cnt = s_q.cnt + 4'h1;
                end
                I2C_TX_ACK:
                begin
                    // Master's not-acknowledge ends the read
                    if (sda)
                        s_d.st = I2C_WAIT;
                end
                I2C_IDLE, I2C_DEV_ACK, I2C_PTR_ACK,
                I2C_WR_ACK, I2C_TX, I2C_WAIT:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (s_q.st)
                I2C_DEV:
                begin
                    if (s_q.cnt == BIT_LAST && dev_match)
                    begin
                        s_d.st = I2C_DEV_ACK;
                        s_d.rw = s_q.sh[0];
                        s_d.sda_oe = 1'b1;
                    end
                    else if (s_q.cnt == BIT_LAST)
                    begin
                        s_d.st = I2C_WAIT;
                    end
                end
                I2C_PTR:
                begin
                    if (s_q.cnt == BIT_LAST)
                    begin
                        s_d.ptr = s_q.sh[5:0];
                        s_d.st = I2C_PTR_ACK;
                        s_d.sda_oe = 1'b1;
                    end
                end
                I2C_WR:
                begin
                    if (s_q.cnt == BIT_LAST)
                    begin
                        wr_en = 1'b1;
                        wr_addr = s_q.ptr;
                        wr_data = s_q.sh;
                        s_d.ptr = s_q.ptr + 6'h01;
                        s_d.st = I2C_WR_ACK;
                        s_d.sda_oe = 1'b1;
                    end
                end
                I2C_DEV_ACK, I2C_TX_ACK:
                begin
                    if (s_q.rw)
                    begin
                        // Present the byte at the pointer, msb first
                        s_d.sh = s_q.regs[s_q.ptr];
                        s_d.sda_oe = ~s_q.regs[s_q.ptr][7];
                        s_d.cnt = 4'h1;
                        s_d.st = I2C_TX;
                    end
                    else
                    begin
                        s_d.sda_oe = 1'b0;
                        s_d.cnt = 4'h0;
                        s_d.st = I2C_PTR;
                    end
                end
                I2C_PTR_ACK, I2C_WR_ACK:
                begin
                    s_d.sda_oe = 1'b0;
                    s_d.cnt = 4'h0;
                    s_d.st = I2C_WR;
                end
                I2C_TX:
                begin
                    if (s_q.cnt == BIT_LAST)
                    begin
                        // Release for the master's acknowledge
                        s_d.sda_oe = 1'b0;
                        s_d.ptr = s_q.ptr + 6'h01;
                        s_d.st = I2C_TX_ACK;
                    end
                    else
                    begin
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                        s_d.sda_oe = ~s_q.sh[6];
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
                I2C_IDLE, I2C_WAIT:
                begin
                end
            endcase
        end

        // Shared write port; commands are magic writes, not stored
        if (wr_en)
        begin
            if (wr_addr == ADDR_PRESET)
            begin
                if (wr_data == CMD_MAGIC)
                begin
                    s_d.regs = {REG_COUNT{REG_RESET_VAL}};
                    s_d.preset = 1'b1;
                end
            end
            else if (wr_addr == ADDR_CALIB)
            begin
                s_d.calib = wr_data == CMD_MAGIC;
            end
            else
            begin
                s_d.regs[wr_addr] = wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Single state register
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= CORE_RESET;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////

    // Outputs straight from flops
    assign spi_miso_o = spi_miso; // Link-clock flop
    assign spi_miso_oe_o = s_q.miso_oe;
    assign two_wire_data_pin_o = s_q.sda_o;
    assign two_wire_data_pin_oe_o = s_q.sda_oe;
    assign reg_file_o = s_q.regs;
    assign restore_defaults_o = s_q.preset;
    assign rc_osc_calibrate_cmd_o = s_q.calib;

endmodule : ssh_serial_host_port

// *** testbench/ssh_serial_host_port_asserts.sv ***
// Pin-level checker for the sensor serial host port
module ssh_serial_host_port_asserts
    import ssh_pkg::*;
(
    // Core clock, reset, strap
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic intf_sel_i,
    // Link and two-wire pins
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_oe_o,
    input wire logic two_wire_clock_pin_i,
    input wire logic two_wire_data_pin_o,
    input wire logic two_wire_data_pin_oe_o,
    // Registers and pulses
    input wire logic [REG_COUNT-1:0][7:0] reg_file_o,
    input wire logic restore_defaults_o,
    input wire logic rc_osc_calibrate_cmd_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////
    // Five cycles cover the select sync lag
    property p_miso_off;
        spi_cs_n_i [*5] |-> !spi_miso_oe_o;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso driven while deselected");
    property p_sel_link;
        intf_sel_i [*5] |-> !spi_miso_oe_o;
    endproperty
    a_sel_link: assert property (p_sel_link) else $error("link active in two-wire mode");
    property p_sel_wire;
        !intf_sel_i [*5] |-> !two_wire_data_pin_oe_o;
    endproperty
    a_sel_wire: assert property (p_sel_wire) else $error("two-wire active in link mode");
    property p_preset;
        restore_defaults_o |-> ##[0:2] (reg_file_o == '0);
    endproperty
    a_preset: assert property (p_preset) else $error("preset left a register set");
    property p_preset_once;
        restore_defaults_o |=> !restore_defaults_o;
    endproperty
    a_preset_once: assert property (p_preset_once) else $error("preset pulse too long");
    property p_cal_once;
        rc_osc_calibrate_cmd_o |=> !rc_osc_calibrate_cmd_o;
    endproperty
    a_cal_once: assert property (p_cal_once) else $error("calibrate pulse too long");
    property p_cmd_excl;
        !(restore_defaults_o && rc_osc_calibrate_cmd_o);
    endproperty
    a_cmd_excl: assert property (p_cmd_excl) else $error("both command pulses at once");
    // Idle link must never disturb the registers
    property p_quiet;
        (spi_cs_n_i && !intf_sel_i) [*8] |=> $stable(reg_file_o);
    endproperty
    a_quiet: assert property (p_quiet) else $error("register change while idle");
    // Data moves only while the bus clock is low, else it fakes start or stop
    property p_ack_edge;
        $changed(two_wire_data_pin_oe_o) |-> !two_wire_clock_pin_i;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("data moved with clock high");
    property p_od_low;
        two_wire_data_pin_o == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("data pin driven high");
    c_preset: cover property (restore_defaults_o);
    c_cal: cover property (rc_osc_calibrate_cmd_o);
    c_ack: cover property ($rose(two_wire_data_pin_oe_o));
    c_miso: cover property ($rose(spi_miso_oe_o));
endmodule : ssh_serial_host_port_asserts

bind ssh_serial_host_port ssh_serial_host_port_asserts i_chk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .intf_sel_i(intf_sel_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_oe_o(spi_miso_oe_o),
    .two_wire_clock_pin_i(two_wire_clock_pin_i),
    .two_wire_data_pin_o(two_wire_data_pin_o),
    .two_wire_data_pin_oe_o(two_wire_data_pin_oe_o),
    .reg_file_o(reg_file_o),
    .restore_defaults_o(restore_defaults_o),
    .rc_osc_calibrate_cmd_o(rc_osc_calibrate_cmd_o)
);

// *** testbench/ssh_host_model.sv ***
// Host master model driving the link and the two-wire bus
module ssh_host_model
    import ssh_pkg::*;
(
    // Link base clock
    input wire logic lclk_i,
    // Serial link
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    // Two-wire bus, resolved level back in
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels: clock low between frames
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    ////////////////////////////////////////
    // Six base ticks: about 1.7 MHz, under the limit and off 500 kHz
    task automatic half();
        repeat (6) @(posedge lclk_i);
        #2;
    endtask : half
    // Deselect flips data so a stale bit is never mistaken for live
    task automatic sel(input logic lvl);
        half();
        cs_n_o = lvl;
        if (lvl)
            mosi_o = ~mosi_o;
        half();
    endtask : sel
    // Shift on rise, sample on fall
    task automatic byte8(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
        begin
            sck_o = 1'b1;
            mosi_o = d[i];
            half();
            sck_o = 1'b0;
            q[i] = miso_i;
            half();
        end
    endtask : byte8
    task automatic i2c_start();
        #250 sda_low_o = 1'b0;
        #250 scl_o = 1'b1;
        #250 sda_low_o = 1'b1;
        #250 scl_o = 1'b0;
    endtask : i2c_start
    task automatic i2c_stop();
        #250 sda_low_o = 1'b1;
        #250 scl_o = 1'b1;
        #250 sda_low_o = 1'b0;
        #250;
    endtask : i2c_stop
    // Nine bits; a 1 releases the line so the other side may drive it
    task automatic i2c_byte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            #250 sda_low_o = ~d[i];
            #250 scl_o = 1'b1;
            #250 q[i] = sda_i;
            #250 scl_o = 1'b0;
        end
    endtask : i2c_byte
endmodule : ssh_host_model

// *** testbench/ssh_serial_host_port_tb.sv ***
// Self-checking bench for the sensor serial host port
module ssh_serial_host_port_tb import ssh_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i, lclk, rst_n_i, sel, a0, a1, sck, cs_n, mosi;
    logic miso, miso_oe, scl, sda_low, sda_oe, sda_do, prst, pcal;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [8:0] r;
    logic [5:0] wa [4] = '{6'h00, 6'h01, 6'h32, 6'h3f};
    logic [7:0] wd [4] = '{8'h11, 8'h22, 8'ha5, 8'h5a};
    int fail_count, n_tests, n_rst, n_cal;
    // Pull-up on data; released link output shows a moving pattern
    wire logic sda = sda_oe ? sda_do : ~sda_low;
    wire logic miso_w = miso_oe ? miso : core_clk_i;

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        lclk = 1'b0;
        #7;
        forever #24 lclk = ~lclk;
    end
    ssh_serial_host_port i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .intf_sel_i(sel), .spi_clk_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .two_wire_clock_pin_i(scl),
        .two_wire_data_pin_i(sda), .two_wire_data_pin_o(sda_do),
        .two_wire_data_pin_oe_o(sda_oe), .addr_pin_0_i(a0), .addr_pin_1_i(a1),
        .reg_file_o(regs), .restore_defaults_o(prst), .rc_osc_calibrate_cmd_o(pcal));
    ssh_host_model i_host (.lclk_i(lclk), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso_w), .scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
    // Count command pulses
    always @(posedge core_clk_i)
    begin
        n_rst += int'(prst === 1'b1);
        n_cal += int'(pcal === 1'b1);
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic spi_cmd(input logic [1:0] m, input logic [5:0] a, input logic [7:0] d);
        i_host.sel(1'b0);
        i_host.byte8({m, a}, r[7:0]);
        i_host.byte8(d, r[7:0]);
        i_host.sel(1'b1);
    endtask : spi_cmd
    // Two-byte burst, closed by a select toggle
    task automatic spi_rd(input logic [5:0] a, input logic [7:0] e0, input logic [7:0] e1);
        i_host.sel(1'b0);
        i_host.byte8({MODE_READ, a}, r[7:0]);
        i_host.byte8(8'h00, r[7:0]);
        chk(r[7:0], e0);
        i_host.byte8(8'h00, r[7:0]);
        chk(r[7:0], e1);
        i_host.sel(1'b1);
        i_host.sel(1'b0);
        i_host.sel(1'b1);
        chk({7'h0, miso_oe}, 8'h00);
    endtask : spi_rd
    // Byte out; ack value 0 means acknowledged
    task automatic tw(input logic [7:0] b, input logic [7:0] ack);
        i_host.i2c_byte({b, 1'b1}, r);
        chk({7'h0, r[0]}, ack);
    endtask : tw
    initial
    begin
        rst_n_i = 1'b0;
        sel = 1'b0;
        a0 = 1'b0;
        a1 = 1'b1;
        repeat (5) @(posedge core_clk_i);
        #2 rst_n_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        chk({7'h0, regs === '0}, 8'h01);
        foreach (wa[i])
        begin
            spi_cmd(MODE_WRITE, wa[i], wd[i]);
            chk(regs[wa[i]], wd[i]);
        end
        spi_cmd(2'h2, 6'h01, 8'hee);
        chk(regs[1], 8'h22);
        spi_rd(6'h32, 8'ha5, 8'h00);
        spi_rd(6'h3f, 8'h5a, 8'h11);
        spi_cmd(MODE_WRITE, ADDR_PRESET, 8'h55);
        chk(8'(n_rst), 8'h00);
        spi_cmd(MODE_WRITE, ADDR_CALIB, CMD_MAGIC);
        chk(8'(n_cal), 8'h01);
        spi_cmd(MODE_WRITE, ADDR_PRESET, CMD_MAGIC);
        chk(8'(n_rst), 8'h01);
        chk({7'h0, regs === '0}, 8'h01);
        @(posedge core_clk_i);
        #2 sel = 1'b1;
        repeat (4) @(posedge core_clk_i);
        spi_cmd(MODE_WRITE, 6'h05, 8'h77);
        chk(regs[5], 8'h00);
        i_host.i2c_start();
        tw(8'h06, 8'h01);
        i_host.i2c_stop();
        i_host.i2c_start();
        tw(8'h04, 8'h00);
        tw(8'h10, 8'h00);
        tw(8'ha5, 8'h00);
        tw(8'h5a, 8'h00);
        i_host.i2c_stop();
        chk(regs[6'h10], 8'ha5);
        chk(regs[6'h11], 8'h5a);
        i_host.i2c_start();
        tw(8'h04, 8'h00);
        tw(8'h10, 8'h00);
        i_host.i2c_start();
        tw(8'h05, 8'h00);
        i_host.i2c_byte({8'hff, 1'b0}, r);
        chk(r[8:1], 8'ha5);
        i_host.i2c_byte({8'hff, 1'b1}, r);
        chk(r[8:1], 8'h5a);
        i_host.i2c_stop();
        i_host.i2c_start();
        tw(8'h04, 8'h00);
        tw({2'h0, ADDR_CALIB}, 8'h00);
        tw(CMD_MAGIC, 8'h00);
        i_host.i2c_stop();
        chk(8'(n_cal), 8'h02);
        // Move the low address pin so the other strap level is matched too
        #2 a0 = 1'b1;
        repeat (4) @(posedge core_clk_i);
        i_host.i2c_start();
        tw(8'h06, 8'h00);
        i_host.i2c_stop();
        i_host.i2c_start();
        tw(8'h04, 8'h01);
        i_host.i2c_stop();
        tally_and_finish();
    end
    // Run needs about 0.3 ms; cut hangs at 1 ms
    initial
    begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
endmodule : ssh_serial_host_port_tb
